// File: design/est_pkg.sv
// Shared constants and types of the exchange sequence tracker
package est_pkg;

  localparam logic [15:0] EST_XID_NONE = 16'hFFFF;

  // APB register byte offsets
  localparam logic [7:0] EST_A_CTRL = 8'h00;
  localparam logic [7:0] EST_A_EDT = 8'h04;
  localparam logic [7:0] EST_A_RQT = 8'h08;
  localparam logic [7:0] EST_A_SEL = 8'h0C;
  localparam logic [7:0] EST_A_STAT = 8'h10;
  localparam logic [7:0] EST_A_ENT_ID = 8'h14;
  localparam logic [7:0] EST_A_ENT_ST = 8'h18;

  // Control register fields
  localparam int EST_C_EN = 0;
  localparam int EST_C_EXTOX = 1;
  localparam int EST_C_EXTRX = 2;
  localparam int EST_C_ILK = 3;
  localparam int EST_C_CL3 = 4;
  localparam int EST_C_W = 5;
  localparam logic [4:0] EST_CTRL_RST = 5'h01;

  // Timeouts in milliseconds and their clock counts
  localparam int EST_CLK_KHZ = 10_000;
  localparam int EST_EDT_MS = 2;
  localparam int EST_RQT_MS = 10;
  localparam int EST_EDT_CYC = EST_EDT_MS * EST_CLK_KHZ;
  localparam int EST_RQT_CYC = EST_RQT_MS * EST_CLK_KHZ;

  // Sequence and exchange status codes
  localparam logic [1:0] EST_ST_OPEN = 2'h0;
  localparam logic [1:0] EST_ST_NORM = 2'h1;
  localparam logic [1:0] EST_ST_ABN = 2'h2;
  localparam logic [1:0] EST_ABC_NONE = 2'h0;

  // One exchange and its current sequence
  typedef struct packed {
    logic vld;
    logic resp;
    logic [15:0] ox;
    logic [15:0] rx;
    logic sq_open;
    logic sq_act;
    logic [1:0] sq_abc;
    logic [1:0] sq_st;
    logic [1:0] x_st;
    logic lseq;
    logic hold;
    logic tmo;
  } est_ent_s;

endpackage : est_pkg

// File: design/est_tmo.sv
// Per-exchange countdown used for hold-open timeouts
`timescale 1ns/10ps
module est_tmo #(
  parameter int W = 32
) (
  input wire logic sys_clk, // 10 MHz clock
  input wire logic reset_n, // Async reset
  input wire logic start, // Load and run
  input wire logic [W-1:0] load, // Cycles to wait
  output logic done // One-cycle expiry pulse
);

  typedef struct packed {
    logic busy;
    logic [W-1:0] cnt;
    logic done;
  } est_tmo_s;

  est_tmo_s q;
  est_tmo_s n;

  always_comb
  begin
    n = q;
    n.done = 1'b0;
    if (start)
    begin
      n.busy = 1'b1;
      n.cnt = load;
    end
    else if (q.busy)
    begin
      if (q.cnt == '0)
      begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
      else
        n.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= n;
  end

  assign done = q.done;

endmodule : est_tmo

// File: design/est_tracker.sv
// Exchange and sequence status tracker with APB registers
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module est_tracker
  import est_pkg::*;
#(
  parameter int NX = 4,
  parameter int IW = 2,
  parameter logic [31:0] EDT_DEF = 32'(est_pkg::EST_EDT_CYC),
  parameter logic [31:0] RQT_DEF = 32'(est_pkg::EST_RQT_CYC)
) (
  input wire logic sys_clk, // 10 MHz clock
  input wire logic reset_n, // Async reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic tx_frm, // Frame about to be sent
  input wire logic tx_new, // Frame opens a new exchange
  input wire logic [IW-1:0] tx_idx, // Exchange slot of frame
  input wire logic tx_ack, // Frame is an ACK
  input wire logic tx_eoft, // ACK ends the sequence
  input wire logic [1:0] tx_abc, // ACK abort condition bits
  input wire logic tx_end, // Last data frame of sequence
  input wire logic tx_lseq, // Request last-sequence bit
  input wire logic rx_frm, // Frame received
  input wire logic rx_first, // First-sequence flag
  input wire logic rx_ctx, // Exchange context bit
  input wire logic [15:0] rx_ox, // Originator identifier
  input wire logic [15:0] rx_rx, // Responder identifier
  input wire logic rx_ack, // Frame is an ACK
  input wire logic rx_eoft, // ACK ends the sequence
  input wire logic rx_end, // Last data frame of sequence
  input wire logic rx_lseq, // Last-sequence bit
  input wire logic abts_acc, // Abort accepted
  input wire logic seq_abort, // Sequence ended abnormally
  input wire logic [IW-1:0] ev_idx, // Slot for abort events
  input wire logic logout, // Logout with peer completed
  output logic hdr_vld, // Header fields valid
  output logic hdr_err, // Frame refused
  output logic [IW-1:0] hdr_idx, // Slot used
  output logic [15:0] hdr_ox, // Originator identifier
  output logic [15:0] hdr_rx, // Responder identifier
  output logic hdr_ctx, // Exchange context bit
  output logic hdr_lseq, // Last-sequence bit
  output logic [NX-1:0] tx_hold, // Slots withheld by interlock
  output logic rx_vld, // Receive lookup done
  output logic rx_hit, // Receive frame matched or opened a slot
  output logic [IW-1:0] rx_idx, // Matched or opened slot
  output logic full // No free slot
);

  typedef struct packed {
    est_ent_s [NX-1:0] e;
    logic [EST_C_W-1:0] ctrl;
    logic [31:0] edt;
    logic [31:0] rqt;
    logic [IW-1:0] sel;
    logic [15:0] ox_ctr;
    logic [15:0] rx_ctr;
    logic hdr_vld;
    logic hdr_err;
    logic [IW-1:0] hdr_idx;
    logic [15:0] hdr_ox;
    logic [15:0] hdr_rx;
    logic hdr_ctx;
    logic hdr_lseq;
    logic rx_vld;
    logic rx_hit;
    logic [IW-1:0] rx_idx;
    logic [31:0] prdata;
    logic pslverr;
  } est_st_s;

  est_st_s q;
  est_st_s n;
  logic [NX-1:0] vld_v;
  logic [NX-1:0] orig_v;
  logic [NX-1:0] tstart;
  logic [NX-1:0] tdone;
  logic [31:0] tload [NX];
  logic [IW:0] ff;
  logic [IW:0] mt;
  logic [IW-1:0] ti;
  logic [15:0] nid;
  est_ent_s ce;

  function automatic logic [IW:0] first_free(input logic [NX-1:0] v);
    logic [IW:0] r;
    r = '0;
    for (int k = NX - 1; k >= 0; k--)
      if (!v[k])
        r = {1'b1, IW'(k)};
    return r;
  endfunction : first_free

  function automatic logic [IW:0] find(input est_ent_s [NX-1:0] e, input logic resp, input logic [15:0] ox);
    logic [IW:0] r;
    r = '0;
    for (int k = NX - 1; k >= 0; k--)
      if (e[k].vld && e[k].resp == resp && e[k].ox == ox)
        r = {1'b1, IW'(k)};
    return r;
  endfunction : find

  // Close the current sequence with a final status
  function automatic est_ent_s seq_done(input est_ent_s e, input logic [1:0] st);
    est_ent_s r;
    r = e;
    r.sq_open = 1'b0;
    r.sq_act = 1'b0;
    r.sq_st = st;
    r.x_st = st;
    if (st == EST_ST_NORM && e.lseq)
      r.vld = 1'b0;
    return r;
  endfunction : seq_done

  function automatic logic [15:0] next_id(input logic [15:0] c);
    logic [15:0] r;
    r = c + 16'h0001;
    // The all-ones value means unassigned, never hand it out
    if (r == EST_XID_NONE)
      r = 16'h0000;
    return r;
  endfunction : next_id

  function automatic logic map_ok(input logic [7:0] a);
    return a == EST_A_CTRL || a == EST_A_EDT || a == EST_A_RQT || a == EST_A_SEL ||
      a == EST_A_STAT || a == EST_A_ENT_ID || a == EST_A_ENT_ST;
  endfunction : map_ok

  function automatic est_ent_s fresh(input logic resp, input logic [15:0] ox, input logic [15:0] rx);
    est_ent_s r;
    r = '0;
    r.vld = 1'b1;
    r.resp = resp;
    r.ox = ox;
    r.rx = rx;
    r.sq_open = 1'b1;
    r.sq_act = 1'b1;
    r.sq_st = EST_ST_OPEN;
    r.x_st = EST_ST_OPEN;
    return r;
  endfunction : fresh

  always_comb
  begin
    n = q;
    tstart = '0;
    ce = '0;
    ti = tx_idx;
    nid = '0;
    for (int k = 0; k < NX; k++)
    begin
      vld_v[k] = q.e[k].vld;
      orig_v[k] = q.e[k].vld && !q.e[k].resp;
      tload[k] = q.rqt;
    end
    ff = first_free(vld_v);
    mt = find(q.e, !rx_ctx, rx_ox);
    n.hdr_vld = 1'b0;
    n.hdr_err = 1'b0;
    n.rx_vld = 1'b0;

    if (tx_frm)
    begin
      if (!q.ctrl[EST_C_EN])
        n.hdr_err = 1'b1;
      else if (tx_new)
      begin
        if (!ff[IW] || (q.ctrl[EST_C_EXTOX] && |orig_v))
          n.hdr_err = 1'b1;
        else
        begin
          ti = ff[IW-1:0];
          nid = q.ctrl[EST_C_EXTOX] ? EST_XID_NONE : q.ox_ctr;
          if (!q.ctrl[EST_C_EXTOX])
            n.ox_ctr = next_id(q.ox_ctr);
          ce = fresh(1'b0, nid, EST_XID_NONE);
          ce.sq_act = !tx_end;
          ce.lseq = tx_lseq;
          // Interlock only applies in Class 2
          ce.hold = q.ctrl[EST_C_ILK] && !q.ctrl[EST_C_CL3];
          if (q.ctrl[EST_C_CL3] && tx_end)
            ce = seq_done(ce, EST_ST_NORM);
          n.e[ti] = ce;
          n.hdr_vld = 1'b1;
        end
      end
      else if (!q.e[ti].vld || (q.e[ti].hold && !tx_ack))
        n.hdr_err = 1'b1;
      else
      begin
        ce = q.e[ti];
        if (!tx_ack)
        begin
          if (!ce.sq_open)
          begin
            ce.sq_open = 1'b1;
            ce.sq_st = EST_ST_OPEN;
            ce.sq_abc = EST_ABC_NONE;
            ce.lseq = tx_lseq;
          end
          else
            ce.lseq = ce.lseq | tx_lseq;
          ce.sq_act = !tx_end;
          if (q.ctrl[EST_C_CL3] && tx_end)
            ce = seq_done(ce, EST_ST_NORM);
        end
        else
        begin
          if (tx_abc != EST_ABC_NONE)
            ce.sq_abc = tx_abc;
          if (tx_eoft)
            ce = seq_done(ce, EST_ST_NORM);
        end
        n.e[ti] = ce;
        n.hdr_vld = 1'b1;
      end
      n.hdr_idx = ti;
      n.hdr_ox = n.e[ti].ox;
      n.hdr_rx = n.e[ti].rx;
      n.hdr_ctx = n.e[ti].resp;
      n.hdr_lseq = ce.lseq && !tx_ack;
    end

    if (rx_frm && q.ctrl[EST_C_EN])
    begin
      n.rx_vld = 1'b1;
      n.rx_hit = 1'b0;
      if (!rx_ctx && rx_first && !mt[IW])
      begin
        if (ff[IW] && !(tx_frm && tx_new))
        begin
          nid = q.ctrl[EST_C_EXTRX] ? EST_XID_NONE : q.rx_ctr;
          if (!q.ctrl[EST_C_EXTRX])
            n.rx_ctr = next_id(q.rx_ctr);
          ce = fresh(1'b1, rx_ox, nid);
          ce.lseq = rx_lseq;
          if (q.ctrl[EST_C_CL3] && rx_end)
            ce = seq_done(ce, EST_ST_NORM);
          n.e[ff[IW-1:0]] = ce;
          n.rx_hit = 1'b1;
          n.rx_idx = ff[IW-1:0];
        end
      end
      else if (mt[IW])
      begin
        ce = n.e[mt[IW-1:0]];
        // Capture the identifier the responder assigned
        if (!ce.resp && ce.rx == EST_XID_NONE && rx_rx != EST_XID_NONE)
          ce.rx = rx_rx;
        if (rx_ack)
        begin
          if (!ce.resp && rx_rx != EST_XID_NONE)
            ce.hold = 1'b0;
          if (rx_eoft)
            ce = seq_done(ce, EST_ST_NORM);
        end
        else
        begin
          if (!ce.sq_open)
          begin
            ce.sq_open = 1'b1;
            ce.sq_st = EST_ST_OPEN;
            ce.sq_abc = EST_ABC_NONE;
            ce.lseq = rx_lseq;
          end
          else
            ce.lseq = ce.lseq | rx_lseq;
          ce.sq_act = !rx_end;
          if (q.ctrl[EST_C_CL3] && rx_end)
            ce = seq_done(ce, EST_ST_NORM);
        end
        n.e[mt[IW-1:0]] = ce;
        n.rx_hit = 1'b1;
        n.rx_idx = mt[IW-1:0];
      end
    end

    // Abort events are applied after frames so that they win
    if (seq_abort && n.e[ev_idx].vld)
    begin
      ce = seq_done(n.e[ev_idx], EST_ST_ABN);
      if (ce.lseq)
      begin
        ce.tmo = 1'b1;
        tstart[ev_idx] = 1'b1;
        tload[ev_idx] = q.edt;
      end
      n.e[ev_idx] = ce;
    end
    if (abts_acc && n.e[ev_idx].vld)
    begin
      ce = seq_done(n.e[ev_idx], EST_ST_ABN);
      ce.tmo = 1'b1;
      ce.hold = 1'b0;
      tstart[ev_idx] = 1'b1;
      tload[ev_idx] = q.rqt;
      n.e[ev_idx] = ce;
    end
    for (int k = 0; k < NX; k++)
    begin
      if (logout && n.e[k].vld)
      begin
        n.e[k] = seq_done(n.e[k], EST_ST_ABN);
        n.e[k].x_st = EST_ST_ABN;
        n.e[k].tmo = 1'b1;
        n.e[k].hold = 1'b0;
        tstart[k] = 1'b1;
        tload[k] = q.rqt;
      end
      // A restart in the same cycle keeps the exchange waiting
      if (tdone[k] && q.e[k].tmo && !tstart[k])
      begin
        n.e[k].vld = 1'b0;
        n.e[k].tmo = 1'b0;
        n.e[k].sq_open = 1'b0;
        n.e[k].sq_act = 1'b0;
      end
    end

    // APB: data latched in setup, answered in the access cycle
    if (psel && !penable)
    begin
      n.pslverr = !map_ok(paddr) || (pwrite && (paddr == EST_A_STAT ||
        paddr == EST_A_ENT_ID || paddr == EST_A_ENT_ST));
      n.prdata = '0;
      if (!pwrite)
      begin
        unique case (paddr)
          EST_A_CTRL: n.prdata = 32'(q.ctrl);
          EST_A_EDT: n.prdata = q.edt;
          EST_A_RQT: n.prdata = q.rqt;
          EST_A_SEL: n.prdata = 32'(q.sel);
          EST_A_STAT: n.prdata = {15'h0000, !ff[IW], 8'h00, 8'(vld_v)};
          EST_A_ENT_ID: n.prdata = {q.e[q.sel].ox, q.e[q.sel].rx};
          EST_A_ENT_ST: n.prdata = {19'h0_0000, q.e[q.sel].vld, q.e[q.sel].resp, q.e[q.sel].sq_open,
            q.e[q.sel].sq_act, q.e[q.sel].sq_abc, q.e[q.sel].sq_st, q.e[q.sel].x_st,
            q.e[q.sel].lseq, q.e[q.sel].hold, q.e[q.sel].tmo};
          default: n.prdata = '0;
        endcase
      end
    end
    if (psel && penable && pwrite && !q.pslverr)
    begin
      unique case (paddr)
        EST_A_CTRL: n.ctrl = pwdata[EST_C_W-1:0];
        EST_A_EDT: n.edt = pwdata;
        EST_A_RQT: n.rqt = pwdata;
        EST_A_SEL: n.sel = pwdata[IW-1:0];
        default: n.sel = q.sel;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.ctrl <= EST_CTRL_RST;
      q.edt <= EDT_DEF;
      q.rqt <= RQT_DEF;
    end
    else
      q <= n;
  end

  genvar g;
  generate
    for (g = 0; g < NX; g++)
    begin : g_tmo
      est_tmo #(
        .W(32)
      ) u_tmo (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .start(tstart[g]),
        .load(tload[g]),
        .done(tdone[g])
      );
      assign tx_hold[g] = q.e[g].hold;
    end
  endgenerate

  assign pready = psel & penable;
  assign pslverr = q.pslverr;
  assign prdata = q.prdata;
  assign hdr_vld = q.hdr_vld;
  assign hdr_err = q.hdr_err;
  assign hdr_idx = q.hdr_idx;
  assign hdr_ox = q.hdr_ox;
  assign hdr_rx = q.hdr_rx;
  assign hdr_ctx = q.hdr_ctx;
  assign hdr_lseq = q.hdr_lseq;
  assign rx_vld = q.rx_vld;
  assign rx_hit = q.rx_hit;
  assign rx_idx = q.rx_idx;
  assign full = !ff[IW];

endmodule : est_tracker

// File: testbench/est_tracker_sva.sv
// Concurrent checks on the tracker's frame and header ports
`timescale 1ns/10ps
module est_tracker_sva
  import est_pkg::*;
#(
  parameter int NX = 4,
  parameter int IW = 2
) (
  input wire logic sys_clk, // Clock
  input wire logic reset_n, // Async reset
  input wire logic tx_frm, // Frame sent
  input wire logic tx_new, // Opens exchange
  input wire logic tx_ack, // Frame is ACK
  input wire logic tx_lseq, // Last-sequence request
  input wire logic rx_frm, // Frame received
  input wire logic full, // No free slot
  input wire logic hdr_vld, // Header valid
  input wire logic hdr_err, // Frame refused
  input wire logic [15:0] hdr_rx, // Responder identifier
  input wire logic [15:0] hdr_ox, // Originator identifier
  input wire logic hdr_ctx, // Context bit
  input wire logic hdr_lseq, // Last-sequence bit
  input wire logic rx_vld, // Receive done
  input wire logic [NX-1:0] tx_hold // Interlock holds
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  a_hdr_answer: assert property (tx_frm |=> hdr_vld != hdr_err)
    else $error("frame got no single answer");
  a_hdr_quiet: assert property (!tx_frm |=> !hdr_vld && !hdr_err)
    else $error("answer without frame");
  a_first_frame: assert property (tx_frm && tx_new |=> hdr_err || (hdr_rx == EST_XID_NONE && !hdr_ctx))
    else $error("first frame fields wrong");
  a_hdr_stand: assert property (!tx_frm |=> $stable(hdr_ox) && $stable(hdr_rx))
    else $error("header fields moved");
  a_ack_lseq: assert property (tx_frm && tx_ack |=> hdr_err || !hdr_lseq)
    else $error("ACK carries last-sequence bit");
  a_lseq_set: assert property (tx_frm && tx_lseq && !tx_ack |=> hdr_err || hdr_lseq)
    else $error("last-sequence bit dropped");
  a_full_refuse: assert property (tx_frm && tx_new && full |=> hdr_err)
    else $error("new exchange taken while full");
  a_rx_quiet: assert property (!rx_frm |=> !rx_vld)
    else $error("receive done without frame");
  a_hold_cause: assert property (|(tx_hold & ~$past(tx_hold)) |-> $past(tx_frm))
    else $error("hold rose without frame");
endmodule : est_tracker_sva

// File: testbench/est_peer.sv
// Peer node model driving the receive frame lines
`timescale 1ns/10ps
module est_peer
  import est_pkg::*;
#(
  parameter logic [15:0] RID = 16'h0123
) (
  input wire logic sys_clk, // Clock
  input wire logic reset_n, // Async reset
  input wire logic hdr_vld, // Device sent a frame
  input wire logic hdr_ctx, // Its context bit
  input wire logic [15:0] hdr_ox, // Its originator identifier
  input wire logic ack_en, // Answer with ACK
  input wire logic eoft, // ACK ends sequence
  input wire logic [3:0] dly, // ACK delay cycles
  input wire logic open_req, // Send first-sequence frame
  input wire logic [15:0] open_ox, // Its originator identifier
  output logic rx_frm, // Frame strobe
  output logic rx_first, // First sequence
  output logic rx_ctx, // Context bit
  output logic [15:0] rx_ox, // Originator identifier
  output logic [15:0] rx_rx, // Responder identifier
  output logic rx_ack, // Frame is ACK
  output logic rx_eoft, // ACK ends sequence
  output logic rx_end, // Last data frame
  output logic rx_lseq // Last-sequence bit
);
  logic pend;
  logic [3:0] cnt;
  logic [15:0] ox_q;
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {rx_frm, rx_first, rx_ctx, rx_ack, rx_eoft, rx_end, rx_lseq, pend} <= '0;
      {rx_ox, rx_rx, cnt, ox_q} <= '0;
    end
    else
    begin
      // Released lines toggle so a stale value never looks valid
      rx_frm <= 1'b0;
      {rx_ox, rx_rx, rx_ctx, rx_ack, rx_eoft, rx_first} <= ~{rx_ox, rx_rx, rx_ctx, rx_ack, rx_eoft, rx_first};
      if (open_req)
      begin
        {rx_frm, rx_first, rx_ctx, rx_ack, rx_eoft} <= 5'h18;
        {rx_ox, rx_rx} <= {open_ox, EST_XID_NONE};
      end
      else if (pend && cnt == 4'h0)
      begin
        {rx_frm, rx_first, rx_ctx, rx_ack, rx_eoft} <= {4'hB, eoft};
        {rx_ox, rx_rx} <= {ox_q, RID};
        pend <= 1'b0;
      end
      else if (pend)
        cnt <= cnt - 4'h1;
      if (hdr_vld && !hdr_ctx && ack_en)
      begin
        pend <= 1'b1;
        cnt <= dly;
        ox_q <= hdr_ox;
      end
    end
  end
endmodule : est_peer

// File: testbench/est_tracker_bench.sv
// Self-checking bench of the exchange sequence tracker
`timescale 1ns/10ps
module est_tracker_bench;
  import est_pkg::*;
  localparam logic [15:0] PEER_RX = 16'h0123;
  logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic tx_frm = 0, tx_new = 0, tx_ack = 0, tx_eoft = 0, tx_end = 0, tx_lseq = 0;
  logic abts_acc = 0, seq_abort = 0, logout = 0, ack_en = 0, eoft = 0, open_req = 0;
  logic [1:0] tx_idx = '0, tx_abc = '0, ev_idx = '0, hdr_idx, rx_idx;
  logic [3:0] dly = '0, tx_hold;
  logic [15:0] open_ox = '0, rx_ox, rx_rx, hdr_ox, hdr_rx;
  logic rx_frm, rx_first, rx_ctx, rx_ack, rx_eoft, rx_end, rx_lseq;
  logic hdr_vld, hdr_err, hdr_ctx, hdr_lseq, rx_vld, rx_hit, full;
  int error_cnt = 0, comparisons = 0;
  int live[4];
  logic [15:0] oxs[$];
  always #50 sys_clk = ~sys_clk;
  est_tracker #(.EDT_DEF(32'h0000_0014), .RQT_DEF(32'h0000_0014)) uut (.*);
  est_peer #(.RID(PEER_RX)) peer (.*);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic ent(input logic [1:0] s);
    apb(1, EST_A_SEL, 32'(s));
    apb(0, EST_A_ENT_ST, 32'h0000_0000);
  endtask : ent
  task automatic stat();
    logic [3:0] e;
    for (int i = 0; i < 4; i++) e[i] = live[i] != 0;
    apb(0, EST_A_STAT, 32'h0000_0000);
    chk("stat", {&e, e}, {rd[16], rd[3:0]});
    chk("full", &e, full);
  endtask : stat
  task automatic send(input logic nw, input logic [1:0] ix, input logic ak, input logic [1:0] abc,
                      input logic ed, input logic ls);
    @(posedge sys_clk);
    {tx_frm, tx_new, tx_idx, tx_ack, tx_abc, tx_end, tx_lseq, tx_eoft} <= {1'b1, nw, ix, ak, abc, ed, ls, ak & ed};
    @(posedge sys_clk);
    tx_frm <= 1'b0;
    #1;
  endtask : send
  task automatic wait_rx();
    int n;
    n = 0;
    do @(posedge sys_clk); while (rx_vld !== 1'b1 && ++n < 40);
    chk("rx_hit", 1, {rx_vld, rx_hit} == 2'h3);
  endtask : wait_rx
  task automatic evt(input int k, input logic [1:0] s);
    @(posedge sys_clk);
    ev_idx <= s;
    {abts_acc, seq_abort, logout} <= 3'(1 << k);
    @(posedge sys_clk);
    {abts_acc, seq_abort, logout} <= 3'h0;
  endtask : evt
  task automatic open_frame();
    @(posedge sys_clk);
    open_req <= 1'b1;
    @(posedge sys_clk);
    open_req <= 1'b0;
    wait_rx();
  endtask : open_frame
  task automatic arm(input logic a, input logic e);
    // Armed on an edge so an older header pulse is not answered
    @(posedge sys_clk);
    {ack_en, eoft} <= {a, e};
    dly <= 4'($urandom % 6);
  endtask : arm
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #400_000;
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    logic [1:0] sl[4];
    logic [15:0] oxof[4];
    logic [1:0] s;
    void'($urandom(71180));
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    apb(0, EST_A_EDT, 32'h0000_0000);
    chk("edt", 32'h0000_0014, rd);
    apb(1, EST_A_RQT, 32'h0000_0008);
    apb(0, EST_A_RQT, 32'h0000_0000);
    chk("rqt", 32'h0000_0008, rd);
    apb(0, 8'h40, 32'h0000_0000);
    chk("unmapped", 1, er);
    apb(1, EST_A_STAT, 32'h0000_000F);
    chk("ro_stat", 1, er);
    $display("test registers done");
    for (int i = 0; i < 5; i++)
    begin
      send(1, 0, 0, 0, 0, 0);
      chk("hdr_vld", i < 4, hdr_vld);
      if (i < 4)
      begin
        chk("hdr_ctx", 0, hdr_ctx);
        chk("hdr_rx", EST_XID_NONE, hdr_rx);
        chk("ox_fresh", 0, hdr_ox == EST_XID_NONE || hdr_ox inside {oxs});
        oxs.push_back(hdr_ox);
        sl[i] = hdr_idx;
        oxof[i] = hdr_ox;
        live[hdr_idx] = 1;
      end
    end
    stat();
    $display("test originate done");
    arm(1, 0);
    send(0, sl[1], 0, 0, 0, 0);
    wait_rx();
    ack_en <= 1'b0;
    chk("ack_idx", sl[1], rx_idx);
    send(0, sl[1], 0, 0, 0, 0);
    chk("rx_kept", PEER_RX, hdr_rx);
    chk("ox_kept", oxof[1], hdr_ox);
    send(0, sl[0], 0, 0, 0, 1);
    send(0, sl[0], 0, 0, 0, 0);
    chk("lseq_stick", 1, hdr_lseq);
    arm(1, 1);
    send(0, sl[0], 0, 0, 1, 0);
    wait_rx();
    ack_en <= 1'b0;
    live[sl[0]] = 0;
    repeat (2) @(posedge sys_clk);
    stat();
    $display("test sequence done");
    evt(2, sl[2]);
    ent(sl[2]);
    chk("sq_abn", EST_ST_ABN, rd[6:5]);
    chk("x_abn", EST_ST_ABN, rd[4:3]);
    chk("rq_held", 1, rd[12]);
    send(0, sl[3], 0, 0, 0, 1);
    evt(1, sl[3]);
    ent(sl[3]);
    chk("edt_held", 1, rd[12]);
    live[sl[2]] = 0;
    repeat (25) @(posedge sys_clk);
    live[sl[3]] = 0;
    stat();
    evt(0, 0);
    repeat (14) @(posedge sys_clk);
    live[sl[1]] = 0;
    stat();
    $display("test abort done");
    open_ox <= 16'($urandom % 32'h0000_FFFF);
    open_frame();
    s = rx_idx;
    live[s] = 1;
    send(0, s, 0, 0, 0, 0);
    chk("resp_ctx", 1, hdr_ctx);
    chk("resp_ox", open_ox, hdr_ox);
    chk("resp_rx", 1, hdr_rx != EST_XID_NONE);
    for (int c = 1; c < 4; c++)
    begin
      send(0, s, 1, 2'(c), 0, 0);
      ent(s);
      chk("abc", c, rd[8:7]);
    end
    open_frame();
    chk("resp_idx", s, rx_idx);
    $display("test responder done");
    apb(1, EST_A_CTRL, 32'h0000_0009);
    arm(1, 0);
    send(1, 0, 0, 0, 0, 0);
    s = hdr_idx;
    chk("hold_set", 1, tx_hold[s]);
    send(0, s, 0, 0, 0, 0);
    chk("held_err", 1, hdr_err);
    wait_rx();
    ack_en <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("hold_clr", 0, tx_hold[s]);
    send(0, s, 0, 0, 0, 0);
    chk("hold_rx", PEER_RX, hdr_rx);
    $display("test interlock done");
    // External tracking on both sides, class 3 completion
    apb(1, EST_A_CTRL, 32'h0000_0017);
    send(1, 0, 0, 0, 0, 0);
    chk("ext_one", 1, hdr_err);
    evt(0, 0);
    repeat (14) @(posedge sys_clk);
    send(1, 0, 0, 0, 0, 0);
    chk("ext_ox", EST_XID_NONE, hdr_ox);
    open_frame();
    s = rx_idx;
    send(0, s, 0, 0, 1, 1);
    chk("ext_rx", EST_XID_NONE, hdr_rx);
    chk("ext_echo", open_ox, hdr_ox);
    ent(s);
    chk("c3_freed", 0, rd[12]);
    chk("c3_norm", EST_ST_NORM, rd[6:5]);
    $display("test tracking done");
    tally_and_finish();
  end
endmodule : est_tracker_bench
bind est_tracker est_tracker_sva #(.NX(NX), .IW(IW)) sva (.*);
